// File: crs_core_regs.sv
// core register set: accumulator, aux, status word, stack pointer, data pointer, scratchpad
// Notes on behaviour
// RULE1: core registers all sit in the special function register space.
// RULE2: accumulator serves as source or destination for arithmetic operations.
// RULE3: aux register takes multiply/divide results, otherwise plain scratch byte.
// RULE4: status word holds result flags and working bank select bits.
// RULE5: stack pointer is eight bits, pointing at last stored stack byte.
// RULE6: push increments pointer then writes; pop reads then decrements.
// RULE7: stack lives in scratchpad and may start anywhere within it.
// RULE8: scratchpad gives 128 byte registers at 00H to 7FH.
// RULE9: four banks of eight working registers; not in external data map.
// RULE10: data pointer reachable as two bytes or one sixteen bit word.
// RULE11: stack pointer wraps modulo 256 with no error.
`include "crs_regs.svh"
module crs_core_regs (
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    input  wire crs_pkg::crs_acc_t ACCESS,
    input  wire crs_pkg::crs_op_t  OP,
    input  wire logic [7:0]        PUSH_DATA,
    input  wire logic [15:0]       MULDIV_RES,
    input  wire logic              MULDIV_WE,
    input  wire logic [15:0]       PTR_WDATA,
    input  wire logic [7:0]        FLAGS_IN,
    input  wire logic [7:0]        FLAGS_MASK,
    input  wire logic [2:0]        RREG_SEL,
    output logic [7:0]             RDATA,
    output logic                   RVALID,
    output logic [7:0]             ACC,
    output logic [7:0]             AUX,
    output logic [7:0]             PROGRAM_STATUS_WORD,
    output logic [7:0]             STACK_POINTER,
    output logic [15:0]            DATA_POINTER_REG,
    output logic [7:0]             WREG_DATA,
    output logic [1:0]             BANK
);
    crs_pkg::crs_state_t st;
    crs_pkg::crs_state_t next_st;
    logic [7:0] scratch [0:127];
    logic [6:0] scr_waddr;
    logic [7:0] scr_wdata;
    logic       scr_we;
    logic [6:0] rreg_addr;
    logic [7:0] sp_inc;

    // bank select picks which eight bytes act as working registers
    assign BANK      = st.program_status_word[`CRS_PSW_RS_MSB:`CRS_PSW_RS_LSB]; // RULE4
    assign rreg_addr = {2'h0, BANK, RREG_SEL}; // RULE9
    assign sp_inc    = st.stack_pointer + 8'h01; // RULE11

    // next state of all registers
    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;
        scr_we         = 1'b0;
        scr_waddr      = 7'h00;
        scr_wdata      = 8'h00;
        case (OP)
            crs_pkg::CRS_OP_PUSH: begin
                next_st.stack_pointer = sp_inc; // RULE6
                scr_we    = 1'b1;
                scr_waddr = sp_inc[6:0]; // RULE7
                scr_wdata = PUSH_DATA;
            end
            crs_pkg::CRS_OP_POP: begin
                // byte comes from old pointer, pointer steps afterwards
                next_st.rdata         = scratch[st.stack_pointer[6:0]]; // RULE6
                next_st.rvalid        = 1'b1;
                next_st.stack_pointer = st.stack_pointer - 8'h01; // RULE11
            end
            crs_pkg::CRS_OP_PTR16: begin
                next_st.data_pointer_reg = PTR_WDATA; // RULE10
            end
            default: begin
            end
        endcase
        if (MULDIV_WE) begin
            next_st.acc = MULDIV_RES[7:0]; // RULE3
            next_st.aux = MULDIV_RES[15:8]; // RULE3
        end
        // flag updates from the previous instruction's result
        next_st.program_status_word = (st.program_status_word & ~FLAGS_MASK) | (FLAGS_IN & FLAGS_MASK); // RULE4
        // byte-wide access, sfr space or direct scratchpad
        if (ACCESS.valid && ACCESS.write && OP != crs_pkg::CRS_OP_PUSH) begin
            if (ACCESS.sfr) begin
                if (ACCESS.addr == `CRS_SFR_ACC) begin
                    next_st.acc = ACCESS.wdata; // RULE2
                end else if (ACCESS.addr == `CRS_SFR_AUX) begin
                    next_st.aux = ACCESS.wdata; // RULE3
                end else if (ACCESS.addr == `CRS_SFR_PSW) begin
                    next_st.program_status_word = ACCESS.wdata; // RULE4
                end else if (ACCESS.addr == `CRS_SFR_SP) begin
                    next_st.stack_pointer = ACCESS.wdata; // RULE5
                end else if (ACCESS.addr == `CRS_SFR_DPL) begin
                    next_st.data_pointer_reg[7:0] = ACCESS.wdata; // RULE10
                end else if (ACCESS.addr == `CRS_SFR_DPH) begin
                    next_st.data_pointer_reg[15:8] = ACCESS.wdata; // RULE10
                end
            end else if (ACCESS.addr <= `CRS_SCR_TOP) begin
                scr_we    = 1'b1; // RULE8
                scr_waddr = ACCESS.addr[6:0];
                scr_wdata = ACCESS.wdata;
            end
        end else if (ACCESS.valid && !ACCESS.write && OP != crs_pkg::CRS_OP_POP) begin
            next_st.rvalid = 1'b1;
            if (ACCESS.sfr) begin
                if (ACCESS.addr == `CRS_SFR_ACC) begin
                    next_st.rdata = st.acc; // RULE1
                end else if (ACCESS.addr == `CRS_SFR_AUX) begin
                    next_st.rdata = st.aux;
                end else if (ACCESS.addr == `CRS_SFR_PSW) begin
                    next_st.rdata = st.program_status_word;
                end else if (ACCESS.addr == `CRS_SFR_SP) begin
                    next_st.rdata = st.stack_pointer;
                end else if (ACCESS.addr == `CRS_SFR_DPL) begin
                    next_st.rdata = st.data_pointer_reg[7:0];
                end else if (ACCESS.addr == `CRS_SFR_DPH) begin
                    next_st.rdata = st.data_pointer_reg[15:8];
                end else begin
                    next_st.rdata = 8'h00;
                end
            end else if (ACCESS.addr <= `CRS_SCR_TOP) begin
                next_st.rdata = scratch[ACCESS.addr[6:0]]; // RULE8
            end else begin
                // upper direct range is not scratchpad; reads as zero
                next_st.rdata = 8'h00;
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st               <= '0;
            st.stack_pointer <= `CRS_SP_RESET;
        end else if (CE) begin
            st <= next_st;
        end
    end

    // scratchpad flops; contents are not cleared by reset
    always_ff @(posedge CLK) begin
        if (CE && RST_N && scr_we) begin
            scratch[scr_waddr] <= scr_wdata; // RULE9
        end
    end

    // outputs straight from registers, except WREG_DATA, a scratchpad read addressed by bank and RREG_SEL
    assign RDATA               = st.rdata;
    assign RVALID              = st.rvalid;
    assign ACC                 = st.acc;
    assign AUX                 = st.aux;
    assign PROGRAM_STATUS_WORD = st.program_status_word;
    assign STACK_POINTER       = st.stack_pointer;
    assign DATA_POINTER_REG    = st.data_pointer_reg;
    assign WREG_DATA           = scratch[rreg_addr];

    // checks
    a_push_step: assert property (@(posedge CLK) disable iff (!RST_N) // RULE6
        CE && OP == crs_pkg::CRS_OP_PUSH && !(ACCESS.valid && ACCESS.write && ACCESS.sfr)
        |=> STACK_POINTER == $past(STACK_POINTER) + 8'h01 && scratch[STACK_POINTER[6:0]] == $past(PUSH_DATA))
        else $error("push did not pre-increment and store");
    a_pop_step: assert property (@(posedge CLK) disable iff (!RST_N) // RULE6
        CE && OP == crs_pkg::CRS_OP_POP && !ACCESS.valid
        |=> RVALID && STACK_POINTER == $past(STACK_POINTER) - 8'h01)
        else $error("pop did not post-decrement");
    a_sp_wrap: assert property (@(posedge CLK) disable iff (!RST_N) // RULE11
        CE && OP == crs_pkg::CRS_OP_PUSH && STACK_POINTER == 8'hFF && !ACCESS.valid
        |=> STACK_POINTER == 8'h00)
        else $error("stack pointer did not wrap");
    a_acc_write: assert property (@(posedge CLK) disable iff (!RST_N) // RULE2
        CE && !MULDIV_WE && ACCESS.valid && ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_ACC
        && OP != crs_pkg::CRS_OP_PUSH |=> ACC == $past(ACCESS.wdata))
        else $error("accumulator write lost");
    a_muldiv_res: assert property (@(posedge CLK) disable iff (!RST_N) // RULE3
        CE && MULDIV_WE && !ACCESS.valid |=> {AUX, ACC} == $past(MULDIV_RES))
        else $error("multiply/divide result lost");
    a_flag_merge: assert property (@(posedge CLK) disable iff (!RST_N) // RULE4
        CE && !ACCESS.valid |=> PROGRAM_STATUS_WORD ==
        (($past(PROGRAM_STATUS_WORD) & ~$past(FLAGS_MASK)) | ($past(FLAGS_IN) & $past(FLAGS_MASK))))
        else $error("flag update wrong");
    a_ptr_word: assert property (@(posedge CLK) disable iff (!RST_N) // RULE10
        CE && OP == crs_pkg::CRS_OP_PTR16 && !ACCESS.valid |=> DATA_POINTER_REG == $past(PTR_WDATA))
        else $error("16-bit pointer load lost");
    a_scr_rdback: assert property (@(posedge CLK) disable iff (!RST_N) // RULE8
        CE && ACCESS.valid && ACCESS.write && !ACCESS.sfr && !ACCESS.addr[7] && OP == crs_pkg::CRS_OP_NONE
        ##1 !ACCESS.valid && OP == crs_pkg::CRS_OP_NONE
        ##1 CE && ACCESS.valid && !ACCESS.write && !ACCESS.sfr && ACCESS.addr == $past(ACCESS.addr, 2)
        && OP == crs_pkg::CRS_OP_NONE |=> RDATA == $past(ACCESS.wdata, 3))
        else $error("scratchpad readback mismatch");
    a_freeze_ce: assert property (@(posedge CLK) disable iff (!RST_N) // RULE5
        !CE |=> $stable(STACK_POINTER) && $stable(ACC))
        else $error("state moved with clock enable low");

    // the rest of the state must hold as well, read data included
    a_freeze_regs: assert property (@(posedge CLK) disable iff (!RST_N) // RULE4
        !CE |=> $stable(AUX) && $stable(PROGRAM_STATUS_WORD) && $stable(DATA_POINTER_REG)
        && $stable(RDATA) && $stable(RVALID))
        else $error("register moved with clock enable low");

    // reset is checked without the disable so it is actually observed
    a_reset_sp: assert property (@(posedge CLK) // RULE5
        !RST_N |=> STACK_POINTER == `CRS_SP_RESET)
        else $error("stack pointer reset value wrong");

    // pop hands back the byte at the old pointer
    a_pop_data: assert property (@(posedge CLK) disable iff (!RST_N) // RULE6
        CE && OP == crs_pkg::CRS_OP_POP
        |=> RVALID && RDATA == $past(scratch[STACK_POINTER[6:0]]))
        else $error("pop returned wrong byte");

    // decrement wraps below zero silently
    a_pop_wrap: assert property (@(posedge CLK) disable iff (!RST_N) // RULE11
        CE && OP == crs_pkg::CRS_OP_POP && STACK_POINTER == 8'h00 && !ACCESS.valid
        |=> STACK_POINTER == 8'hFF)
        else $error("stack pointer did not wrap on pop");

    // direct write lands in the addressed scratch byte
    a_scr_write: assert property (@(posedge CLK) disable iff (!RST_N) // RULE8
        CE && ACCESS.valid && ACCESS.write && !ACCESS.sfr && !ACCESS.addr[7] && OP != crs_pkg::CRS_OP_PUSH
        |=> scratch[$past(ACCESS.addr[6:0])] == $past(ACCESS.wdata))
        else $error("scratchpad write lost");

    // no read strobe without a read or pop
    a_rvalid_low: assert property (@(posedge CLK) disable iff (!RST_N) // RULE8
        CE && !(ACCESS.valid && !ACCESS.write) && OP != crs_pkg::CRS_OP_POP
        |=> !RVALID)
        else $error("read valid without request");

    // upper direct range lies outside the scratchpad
    a_upper_zero: assert property (@(posedge CLK) disable iff (!RST_N) // RULE9
        CE && ACCESS.valid && !ACCESS.write && !ACCESS.sfr && ACCESS.addr[7] && OP != crs_pkg::CRS_OP_POP
        |=> RVALID && RDATA == 8'h00)
        else $error("upper direct read not zero");

    // aux byte write through the sfr space
    a_aux_write: assert property (@(posedge CLK) disable iff (!RST_N) // RULE3
        CE && ACCESS.valid && ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_AUX
        && OP != crs_pkg::CRS_OP_PUSH |=> AUX == $past(ACCESS.wdata))
        else $error("aux write lost");

    // status word write wins over the flag merge
    a_psw_write: assert property (@(posedge CLK) disable iff (!RST_N) // RULE4
        CE && ACCESS.valid && ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_PSW
        && OP != crs_pkg::CRS_OP_PUSH |=> PROGRAM_STATUS_WORD == $past(ACCESS.wdata))
        else $error("status word write lost");

    // software may place the stack anywhere
    a_sp_write: assert property (@(posedge CLK) disable iff (!RST_N) // RULE5
        CE && ACCESS.valid && ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_SP
        && OP != crs_pkg::CRS_OP_PUSH |=> STACK_POINTER == $past(ACCESS.wdata))
        else $error("stack pointer write lost");

    // pointer low byte on its own
    a_dpl_write: assert property (@(posedge CLK) disable iff (!RST_N) // RULE10
        CE && ACCESS.valid && ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_DPL
        && OP != crs_pkg::CRS_OP_PUSH |=> DATA_POINTER_REG[7:0] == $past(ACCESS.wdata))
        else $error("pointer low byte write lost");

    // pointer high byte on its own
    a_dph_write: assert property (@(posedge CLK) disable iff (!RST_N) // RULE10
        CE && ACCESS.valid && ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_DPH
        && OP != crs_pkg::CRS_OP_PUSH |=> DATA_POINTER_REG[15:8] == $past(ACCESS.wdata))
        else $error("pointer high byte write lost");

    // accumulator visible in the sfr space
    a_acc_read: assert property (@(posedge CLK) disable iff (!RST_N) // RULE1
        CE && ACCESS.valid && !ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_ACC
        && OP != crs_pkg::CRS_OP_POP |=> RVALID && RDATA == $past(ACC))
        else $error("accumulator read wrong");

    // aux visible in the sfr space
    a_aux_read: assert property (@(posedge CLK) disable iff (!RST_N) // RULE3
        CE && ACCESS.valid && !ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_AUX
        && OP != crs_pkg::CRS_OP_POP |=> RVALID && RDATA == $past(AUX))
        else $error("aux read wrong");

    // status word visible in the sfr space
    a_psw_read: assert property (@(posedge CLK) disable iff (!RST_N) // RULE4
        CE && ACCESS.valid && !ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_PSW
        && OP != crs_pkg::CRS_OP_POP |=> RVALID && RDATA == $past(PROGRAM_STATUS_WORD))
        else $error("status word read wrong");

    // stack pointer visible in the sfr space
    a_sp_read: assert property (@(posedge CLK) disable iff (!RST_N) // RULE5
        CE && ACCESS.valid && !ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_SP
        && OP != crs_pkg::CRS_OP_POP |=> RVALID && RDATA == $past(STACK_POINTER))
        else $error("stack pointer read wrong");

    // pointer low byte readable alone
    a_dpl_read: assert property (@(posedge CLK) disable iff (!RST_N) // RULE10
        CE && ACCESS.valid && !ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_DPL
        && OP != crs_pkg::CRS_OP_POP |=> RVALID && RDATA == $past(DATA_POINTER_REG[7:0]))
        else $error("pointer low byte read wrong");

    // pointer high byte readable alone
    a_dph_read: assert property (@(posedge CLK) disable iff (!RST_N) // RULE10
        CE && ACCESS.valid && !ACCESS.write && ACCESS.sfr && ACCESS.addr == `CRS_SFR_DPH
        && OP != crs_pkg::CRS_OP_POP |=> RVALID && RDATA == $past(DATA_POINTER_REG[15:8]))
        else $error("pointer high byte read wrong");

    // unmapped sfr addresses must read as zero, never stale data
    a_sfr_unmapped: assert property (@(posedge CLK) disable iff (!RST_N) // RULE1
        CE && ACCESS.valid && !ACCESS.write && ACCESS.sfr && OP != crs_pkg::CRS_OP_POP
        && ACCESS.addr != `CRS_SFR_ACC && ACCESS.addr != `CRS_SFR_AUX && ACCESS.addr != `CRS_SFR_PSW
        && ACCESS.addr != `CRS_SFR_SP && ACCESS.addr != `CRS_SFR_DPL && ACCESS.addr != `CRS_SFR_DPH
        |=> RVALID && RDATA == 8'h00)
        else $error("unmapped sfr read not zero");
endmodule : crs_core_regs

// File: crs_regs.svh
// constants for the core register set and scratchpad
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH
`define CRS_SFR_ACC      8'hE0
`define CRS_SFR_AUX      8'hF0
`define CRS_SFR_PSW      8'hD0
`define CRS_SFR_SP       8'h81
`define CRS_SFR_DPL      8'h82
`define CRS_SFR_DPH      8'h83
`define CRS_SP_RESET     8'h07
`define CRS_PSW_RS_LSB   3
`define CRS_PSW_RS_MSB   4
`define CRS_PSW_PAR_BIT  0
`define CRS_SCR_TOP      8'h7F
`endif

// File: crs_pkg.sv
// types shared by the core register set
package crs_pkg;
    typedef enum logic [2:0] {
        CRS_OP_NONE,
        CRS_OP_PUSH,
        CRS_OP_POP,
        CRS_OP_MULDIV,
        CRS_OP_PTR16
    } crs_op_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       sfr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crs_acc_t;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  aux;
        logic [7:0]  program_status_word;
        logic [7:0]  stack_pointer;
        logic [15:0] data_pointer_reg;
        logic [7:0]  rdata;
        logic        rvalid;
    } crs_state_t;
endpackage : crs_pkg

// File: crs_exec_model.sv
// execution-side model feeding multiply results and result flags into the register set
module crs_exec_model (
    input  wire logic [7:0]  acc,
    input  wire logic [7:0]  aux,
    output logic      [15:0] muldiv_res,
    output logic      [7:0]  flags_in
);
    // product of the two operand bytes, high byte lands in aux
    assign muldiv_res = {8'h00, acc} * {8'h00, aux};
    // only parity is modelled; other flags stay low so masked writes are predictable
    assign flags_in   = {7'h00, ^acc};
endmodule : crs_exec_model

// File: test_cpu_register_scratchpad.sv
// self-checking bench for the core register set and scratchpad
`include "crs_regs.svh"
module test_cpu_register_scratchpad;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              ce = 1'b1;
    crs_pkg::crs_acc_t access = '0;
    crs_pkg::crs_op_t  op = crs_pkg::CRS_OP_NONE;
    logic [7:0]        push_data = 8'h00;
    logic              muldiv_we = 1'b0;
    logic [15:0]       ptr_wdata = 16'h0000;
    logic [7:0]        flags_mask = 8'h00;
    logic [2:0]        rreg_sel = 3'h0;
    logic [15:0]       muldiv_res;
    logic [7:0]        flags_in, rdata, acc, aux, program_status_word, sp, wreg;
    logic              rvalid;
    logic [15:0]       dp;
    logic [1:0]        bank;
    int                error_cnt = 0;
    int                n_checks = 0;
    crs_exec_model u_crs_exec_model (.acc(acc), .aux(aux), .muldiv_res(muldiv_res), .flags_in(flags_in));
    crs_core_regs u_crs_core_regs (.CLK(clk), .RST_N(rst_n), .CE(ce), .ACCESS(access), .OP(op),
        .PUSH_DATA(push_data), .MULDIV_RES(muldiv_res), .MULDIV_WE(muldiv_we), .PTR_WDATA(ptr_wdata),
        .FLAGS_IN(flags_in), .FLAGS_MASK(flags_mask), .RREG_SEL(rreg_sel), .RDATA(rdata), .RVALID(rvalid),
        .ACC(acc), .AUX(aux), .PROGRAM_STATUS_WORD(program_status_word), .STACK_POINTER(sp), .DATA_POINTER_REG(dp),
        .WREG_DATA(wreg), .BANK(bank));
    always #4 clk = ~clk;
    // one compare for every result, widened to 16 bits
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // inputs move at the falling edge so the rising edge samples settled values
    task wr(input logic sfr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) access = {1'b1, 1'b1, sfr, a, d};
        @(negedge clk) access = '0;
    endtask : wr
    task rd(input logic sfr, input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk) access = {1'b1, 1'b0, sfr, a, 8'h00};
        @(negedge clk) access = '0;
        chk({15'h0000, rvalid}, 16'h0001);
        chk({8'h00, rdata}, {8'h00, exp});
    endtask : rd
    task do_push(input logic [7:0] d, input logic [7:0] exp_sp);
        @(negedge clk) begin op = crs_pkg::CRS_OP_PUSH; push_data = d; end
        @(negedge clk) op = crs_pkg::CRS_OP_NONE;
        chk({8'h00, sp}, {8'h00, exp_sp});
    endtask : do_push
    task do_pop(input logic [7:0] exp_d, input logic [7:0] exp_sp);
        @(negedge clk) op = crs_pkg::CRS_OP_POP;
        @(negedge clk) op = crs_pkg::CRS_OP_NONE;
        chk({15'h0000, rvalid}, 16'h0001);
        chk({8'h00, rdata}, {8'h00, exp_d});
        chk({8'h00, sp}, {8'h00, exp_sp});
    endtask : do_pop
    task t_sfr;
        wr(1'b1, `CRS_SFR_ACC, 8'h3C);
        wr(1'b1, `CRS_SFR_AUX, 8'hA5);
        wr(1'b1, `CRS_SFR_PSW, 8'h18);
        wr(1'b1, `CRS_SFR_DPL, 8'h34);
        wr(1'b1, `CRS_SFR_DPH, 8'h12);
        wr(1'b1, 8'h90, 8'h5A);
        rd(1'b1, `CRS_SFR_ACC, 8'h3C);
        rd(1'b1, `CRS_SFR_AUX, 8'hA5);
        rd(1'b1, `CRS_SFR_PSW, 8'h18);
        rd(1'b1, 8'h90, 8'h00);
        chk(dp, 16'h1234);
        chk({14'h0000, bank}, 16'h0003);
    endtask : t_sfr
    task t_scratch;
        wr(1'b0, 8'h00, 8'h55);
        wr(1'b0, `CRS_SCR_TOP, 8'hAA);
        wr(1'b0, 8'h1D, 8'h6C);
        rd(1'b0, 8'h00, 8'h55);
        rd(1'b0, `CRS_SCR_TOP, 8'hAA);
        rd(1'b0, 8'h80, 8'h00);
        wr(1'b0, 8'h40, 8'h9C);
        rd(1'b0, 8'h40, 8'h9C);
        @(negedge clk) rreg_sel = 3'h5;
        chk({8'h00, wreg}, 16'h006C);
    endtask : t_scratch
    // stack placed mid-scratchpad, then wrapped through the top of the pointer range
    task t_stack;
        wr(1'b1, `CRS_SFR_SP, 8'h30);
        do_push(8'h11, 8'h31);
        do_push(8'h22, 8'h32);
        rd(1'b0, 8'h32, 8'h22);
        do_pop(8'h22, 8'h31);
        do_pop(8'h11, 8'h30);
        wr(1'b1, `CRS_SFR_SP, 8'hFF);
        do_push(8'h77, 8'h00);
        rd(1'b0, 8'h00, 8'h77);
        do_pop(8'h77, 8'hFF);
    endtask : t_stack
    task t_muldiv;
        wr(1'b1, `CRS_SFR_ACC, 8'h12);
        wr(1'b1, `CRS_SFR_AUX, 8'h10);
        @(negedge clk) muldiv_we = 1'b1;
        @(negedge clk) muldiv_we = 1'b0;
        chk({aux, acc}, 16'h0120);
        rd(1'b1, `CRS_SFR_ACC, 8'h20);
    endtask : t_muldiv
    task t_ptr;
        @(negedge clk) begin op = crs_pkg::CRS_OP_PTR16; ptr_wdata = 16'hBEEF; end
        @(negedge clk) op = crs_pkg::CRS_OP_NONE;
        chk(dp, 16'hBEEF);
        rd(1'b1, `CRS_SFR_DPL, 8'hEF);
        rd(1'b1, `CRS_SFR_DPH, 8'hBE);
    endtask : t_ptr
    // parity of 20h is odd, so the masked flag must come up while bank bits stay
    task t_flags;
        @(negedge clk) flags_mask = 8'h01;
        @(negedge clk) flags_mask = 8'h00;
        chk({8'h00, program_status_word}, 16'h0019);
    endtask : t_flags
    // push and accumulator write offered while the enable is low must both be ignored
    task t_freeze;
        @(negedge clk) begin
            ce = 1'b0;
            op = crs_pkg::CRS_OP_PUSH;
            push_data = 8'hE7;
            access = {1'b1, 1'b1, 1'b1, `CRS_SFR_ACC, 8'h99};
        end
        @(negedge clk) begin
            ce = 1'b1;
            op = crs_pkg::CRS_OP_NONE;
            access = '0;
        end
        chk({8'h00, sp}, 16'h00FF);
        chk({8'h00, acc}, 16'h0020);
    endtask : t_freeze
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        chk({8'h00, sp}, {8'h00, `CRS_SP_RESET});
        chk({acc, aux}, 16'h0000);
        t_sfr();
        t_scratch();
        t_stack();
        t_muldiv();
        t_ptr();
        t_flags();
        t_freeze();
        wrap_up();
    end
    // run needs about 80 cycles; this span is generous
    initial begin
        #(5000 * 8);
        error_cnt++;
        wrap_up();
    end
endmodule : test_cpu_register_scratchpad
